/* File: shared/fram_regs.svh */
// Purpose: constants for the fabric embedded ram blocks
// Assumes: one clock, sys_clk at 250 MHz
// Notes: the rams hold no software registers; these are geometry figures
// Notes on behaviour
// - large ram holds 18,432 bits as 1024 words of 18 bits.
// - large ram has two ports, A and B, each reaching every word.
// - large ram reads and writes are clocked, never combinational.
// - every ram operation except a micro async read is sampled on the rising clock edge.
// - large ram read data has optional pipeline regs with own enable, reset.
// - micro ram holds 1,152 bits as 64 words of 18 bits.
// - micro ram ports A and B only read; port C only writes.
// - micro read ports are independent, each sync or async by choice.
// - micro write port always writes on its clock edge.
`ifndef FRAM_REGS_SVH
`define FRAM_REGS_SVH
`define FRAM_WORD_W      18
`define FRAM_LARGE_DEPTH 1024
`define FRAM_LARGE_AW    10
`define FRAM_LARGE_BITS  18432
`define FRAM_MICRO_DEPTH 64
`define FRAM_MICRO_AW    6
`define FRAM_MICRO_BITS  1152
`define FRAM_DATA_RST    18'h00000
`endif

/* File: shared/fram_pkg.sv */
// Purpose: types shared by the fabric ram blocks
// Assumes: the constants header is on the include path
// Notes: word type is the 18-bit ram word
`include "fram_regs.svh"
package fram_pkg;
	typedef logic [`FRAM_WORD_W-1:0]     fram_word_type;
	typedef logic [`FRAM_LARGE_AW-1:0]   fram_large_addr_type;
	typedef logic [`FRAM_MICRO_AW-1:0]   fram_micro_addr_type;
endpackage

/* File: rtl/fram_micro_three_port_ram.sv */
// Purpose: micro_three_port_ram, 64 x 18, two read ports and one write port
// Assumes: all ports share sys_clk
// Notes: async read output is combinational, so it is not a flop
`timescale 1ns/10ps
`include "fram_regs.svh"
module fram_micro_three_port_ram #(
	parameter int DEPTH = `FRAM_MICRO_DEPTH,
	parameter int AW    = `FRAM_MICRO_AW
) (
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	input  wire logic                  rd_a_sync,
	input  wire logic                  rd_a_en,
	input  wire fram_pkg::fram_micro_addr_type rd_a_addr,
	output logic [`FRAM_WORD_W-1:0]    rd_a_data,
	input  wire logic                  rd_b_sync,
	input  wire logic                  rd_b_en,
	input  wire fram_pkg::fram_micro_addr_type rd_b_addr,
	output logic [`FRAM_WORD_W-1:0]    rd_b_data,
	input  wire logic                  wr_c_en,
	input  wire fram_pkg::fram_micro_addr_type wr_c_addr,
	input  wire fram_pkg::fram_word_type wr_c_data
);
	import fram_pkg::*;
	fram_word_type mem_q [DEPTH];   // 64 words of 18 bits
	fram_word_type rd_a_q;
	fram_word_type rd_b_q;

	// only port c writes, and only on the clock edge
	always_ff @(posedge sys_clk) begin
		if (wr_c_en) begin
			mem_q[wr_c_addr] <= wr_c_data;
		end
	end

	// clocked read registers; array has no reset so reset clears only these
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_a_q <= `FRAM_DATA_RST;
			rd_b_q <= `FRAM_DATA_RST;
		end else begin
			if (rd_a_en) begin
				rd_a_q <= mem_q[rd_a_addr];
			end
			if (rd_b_en) begin
				rd_b_q <= mem_q[rd_b_addr];
			end
		end
	end

	// each port picks its own mode; async reads bypass the clock
	assign rd_a_data = rd_a_sync ? rd_a_q : mem_q[rd_a_addr];
	assign rd_b_data = rd_b_sync ? rd_b_q : mem_q[rd_b_addr];

	// checked against the written word, so unwritten words never count
	a_async_follow: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		wr_c_en && !rd_a_sync ##1 !rd_a_sync && rd_a_addr == $past(wr_c_addr)
		|-> rd_a_data == $past(wr_c_data))
		else $error("async read a does not follow address");
	a_sync_read_b: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		rd_b_en && !(wr_c_en && wr_c_addr == rd_b_addr) ##1 rd_b_sync
		|-> rd_b_data == $past(mem_q[rd_b_addr]))
		else $error("sync read b wrong data");
	a_write_lands: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		wr_c_en |=> mem_q[$past(wr_c_addr)] == $past(wr_c_data))
		else $error("write c did not land");
	c_async_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
		wr_c_en ##1 !rd_a_sync);
endmodule

/* File: rtl/fram_ram_blocks.sv */
// Purpose: large_dual_port_ram (1024 x 18) beside micro_three_port_ram
// Assumes: one clock sys_clk for all ports; inputs synchronous to it
// Notes: same-address write on both large ports: port b wins
// Notes: a write on a port does no read; that port's read register keeps its last word
// Notes: read flops clear on reset; the arrays themselves power up unknown
`timescale 1ns/10ps
`include "fram_regs.svh"
module fram_ram_blocks #(
	parameter int  LDEPTH = `FRAM_LARGE_DEPTH,
	parameter bit  PIPE_A = 1'b1,
	parameter bit  PIPE_B = 1'b1
) (
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	input  wire logic                  la_en,
	input  wire logic                  la_wr,
	input  wire fram_pkg::fram_large_addr_type la_addr,
	input  wire fram_pkg::fram_word_type la_wdata,
	input  wire logic                  la_pipe_en,
	input  wire logic                  la_pipe_rst,
	output fram_pkg::fram_word_type    la_rdata,
	input  wire logic                  lb_en,
	input  wire logic                  lb_wr,
	input  wire fram_pkg::fram_large_addr_type lb_addr,
	input  wire fram_pkg::fram_word_type lb_wdata,
	input  wire logic                  lb_pipe_en,
	input  wire logic                  lb_pipe_rst,
	output fram_pkg::fram_word_type    lb_rdata,
	input  wire logic                  ma_sync,
	input  wire logic                  ma_en,
	input  wire fram_pkg::fram_micro_addr_type ma_addr,
	output fram_pkg::fram_word_type    ma_rdata,
	input  wire logic                  mb_sync,
	input  wire logic                  mb_en,
	input  wire fram_pkg::fram_micro_addr_type mb_addr,
	output fram_pkg::fram_word_type    mb_rdata,
	input  wire logic                  mc_wr,
	input  wire fram_pkg::fram_micro_addr_type mc_addr,
	input  wire fram_pkg::fram_word_type mc_wdata
);
	import fram_pkg::*;
	fram_word_type big_q [LDEPTH];   // 18,432 bits
	fram_word_type la_core_q;
	fram_word_type lb_core_q;
	fram_word_type la_pipe_q;
	fram_word_type lb_pipe_q;
	fram_word_type ma_d;
	fram_word_type mb_d;
	fram_word_type ma_q;
	fram_word_type mb_q;

	// both ports write the whole array on the rising edge
	always_ff @(posedge sys_clk) begin
		if (la_en && la_wr) begin
			big_q[la_addr] <= la_wdata;
		end
		if (lb_en && lb_wr) begin
			big_q[lb_addr] <= lb_wdata;
		end
	end

	// port a core read register, clocked and never combinational
	// a write cycle performs no read, so the register keeps its word
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			la_core_q <= `FRAM_DATA_RST;
		end else if (la_en && !la_wr) begin
			la_core_q <= big_q[la_addr];
		end
	end

	// port b core read register, same timing as port a
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lb_core_q <= `FRAM_DATA_RST;
		end else if (lb_en && !lb_wr) begin
			lb_core_q <= big_q[lb_addr];
		end
	end

	// port a output pipe with its own enable and synchronous clear
	// the clear beats the enable so a flush never lets a word slip out
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			la_pipe_q <= `FRAM_DATA_RST;
		end else if (la_pipe_rst) begin
			la_pipe_q <= `FRAM_DATA_RST;
		end else if (la_pipe_en) begin
			la_pipe_q <= la_core_q;
		end
	end

	// port b output pipe, controlled apart from the array enables
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lb_pipe_q <= `FRAM_DATA_RST;
		end else if (lb_pipe_rst) begin
			lb_pipe_q <= `FRAM_DATA_RST;
		end else if (lb_pipe_en) begin
			lb_pipe_q <= lb_core_q;
		end
	end

	// pipe bypass is a build option, so outputs stay flop driven either way
	assign la_rdata = PIPE_A ? la_pipe_q : la_core_q;
	assign lb_rdata = PIPE_B ? lb_pipe_q : lb_core_q;

	// micro ram; 6-bit addresses come from user logic
	fram_micro_three_port_ram u_micro (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.rd_a_sync (ma_sync),
		.rd_a_en   (ma_en),
		.rd_a_addr (ma_addr),
		.rd_a_data (ma_d),
		.rd_b_sync (mb_sync),
		.rd_b_en   (mb_en),
		.rd_b_addr (mb_addr),
		.rd_b_data (mb_d),
		.wr_c_en   (mc_wr),
		.wr_c_addr (mc_addr),
		.wr_c_data (mc_wdata)
	);
	// async mode must stay combinational, so it cannot pass a flop here
	assign ma_rdata = ma_d;
	assign mb_rdata = mb_d;
	assign ma_q = ma_d;
	assign mb_q = mb_d;

	// large array: clocked reads, writes and the port b clash rule
	// a read sees the word as it stood before the same edge's writes
	a_read_a_core: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		la_en && !la_wr && !(lb_en && lb_wr && lb_addr == la_addr)
		|=> la_core_q == $past(big_q[la_addr]))
		else $error("port a read returned wrong word");
	a_read_b_core: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		lb_en && !lb_wr
		|=> lb_core_q == $past(big_q[lb_addr]))
		else $error("port b read returned wrong word");
	a_core_a_hold: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		la_en && la_wr
		|=> $stable(la_core_q))
		else $error("port a read register moved on a write");
	a_core_b_idle: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		!lb_en
		|=> $stable(lb_core_q))
		else $error("port b read register moved while idle");
	a_write_b_lands: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		lb_en && lb_wr
		|=> big_q[$past(lb_addr)] == $past(lb_wdata))
		else $error("port b write lost");
	a_write_a_lands: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		la_en && la_wr && !(lb_en && lb_wr && lb_addr == la_addr)
		|=> big_q[$past(la_addr)] == $past(la_wdata))
		else $error("port a write lost");
	a_clash_b_wins: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		la_en && la_wr && lb_en && lb_wr && la_addr == lb_addr
		|=> big_q[$past(la_addr)] == $past(lb_wdata))
		else $error("write clash not won by port b");

	// output pipes: clear, hold and load on their own controls
	// these never look at the array enables, which is the point of them
	a_pipe_reset: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		la_pipe_rst
		|=> la_pipe_q == `FRAM_DATA_RST)
		else $error("pipe a did not clear");
	a_pipe_hold: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		!lb_pipe_en && !lb_pipe_rst
		|=> $stable(lb_pipe_q))
		else $error("pipe b moved while disabled");
	a_pipe_a_hold: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		!la_pipe_en && !la_pipe_rst
		|=> $stable(la_pipe_q))
		else $error("pipe a moved while disabled");
	a_pipe_load: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		la_pipe_en && !la_pipe_rst
		|=> la_pipe_q == $past(la_core_q))
		else $error("pipe a did not load");
	a_pipe_b_load: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		lb_pipe_en && !lb_pipe_rst
		|=> lb_pipe_q == $past(lb_core_q))
		else $error("pipe b did not load");

	// micro ram read modes as seen at the top
	// async b must show a word one cycle after port c wrote it
	a_micro_async: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		mc_wr && !mb_sync ##1 !mb_sync && mb_addr == $past(mc_addr)
		|-> mb_rdata == $past(mc_wdata))
		else $error("micro async read b stale");
	a_micro_sync: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		ma_sync && !ma_en ##1 ma_sync && !ma_en
		|-> $stable(ma_q))
		else $error("micro sync read a moved");

	// main scenarios
	c_write_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
		la_en && la_wr ##1 lb_en && !lb_wr && lb_addr == $past(la_addr));
	c_pipe_flow: cover property (@(posedge sys_clk) disable iff (!arst_n)
		la_en && !la_wr ##1 la_pipe_en);
	c_micro_both: cover property (@(posedge sys_clk) disable iff (!arst_n)
		ma_sync && !mb_sync && mc_wr);
endmodule

/* File: dv/fram_fill_model.sv */
// Purpose: fabric user logic that fills the micro ram through port c
// Assumes: one clock shared with the rams
// Notes: one write per cycle, all 64 words, after a start pulse
`timescale 1ns/10ps
module fram_fill_model (
	input  wire logic                     sys_clk,
	input  wire logic                     arst_n,
	input  wire logic                     start,
	output logic                          mc_wr,
	output fram_pkg::fram_micro_addr_type mc_addr,
	output fram_pkg::fram_word_type       mc_wdata,
	output logic                          busy
);
	import fram_pkg::*;
	logic [6:0] cnt_q;

	// word counter; 7'h40 means idle, so a fill never wraps onto word 0
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 7'h40;
		end else if (start) begin
			cnt_q <= 7'h00;
		end else if (cnt_q != 7'h40) begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	// write strobe and data change only just after the edge
	assign busy     = (cnt_q != 7'h40);
	assign mc_wr    = busy;
	assign mc_addr  = cnt_q[5:0];
	assign mc_wdata = {6'h2A, cnt_q[5:0], ~cnt_q[5:0]};
endmodule

/* File: dv/fram_ram_blocks_tb.sv */
// Purpose: self-checking bench for the large and micro ram blocks
// Assumes: pipe registers built in on both large ports
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/10ps
module fram_ram_blocks_tb;
	import fram_pkg::*;
	logic                sys_clk, arst_n, start, fill_busy;
	logic                la_en, la_wr, la_pipe_en, la_pipe_rst;
	logic                lb_en, lb_wr, lb_pipe_en, lb_pipe_rst;
	logic                ma_sync, ma_en, mb_sync, mb_en, mc_wr;
	fram_large_addr_type la_addr, lb_addr;
	fram_micro_addr_type ma_addr, mb_addr, mc_addr;
	fram_word_type       la_wdata, lb_wdata, la_rdata, lb_rdata;
	fram_word_type       ma_rdata, mb_rdata, mc_wdata;
	fram_large_addr_type aa [4] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF};
	fram_large_addr_type bb [4] = '{10'h001, 10'h3FE, 10'h201, 10'h1FE};
	int                  bad_count, cmp_count;

	fram_ram_blocks i_dut (.sys_clk, .arst_n, .la_en, .la_wr, .la_addr,
		.la_wdata, .la_pipe_en, .la_pipe_rst, .la_rdata, .lb_en, .lb_wr,
		.lb_addr, .lb_wdata, .lb_pipe_en, .lb_pipe_rst, .lb_rdata, .ma_sync,
		.ma_en, .ma_addr, .ma_rdata, .mb_sync, .mb_en, .mb_addr, .mb_rdata,
		.mc_wr, .mc_addr, .mc_wdata);
	fram_fill_model i_fill (.sys_clk, .arst_n, .start, .mc_wr, .mc_addr,
		.mc_wdata, .busy(fill_busy));

	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	function automatic fram_word_type pat(input int a);
		return {6'h2A, 6'(a), ~6'(a)};
	endfunction

	task automatic chk(input fram_word_type seen, input fram_word_type exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %0t read %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic stop_test;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// both ports write at the boundaries, then read back crosswise
	task automatic t_large;
		for (int i = 0; i < 4; i++) begin
			la_en = 1'b1; la_wr = 1'b1; la_addr = aa[i];
			la_wdata = 18'h3FFFF ^ 18'(i);
			lb_en = 1'b1; lb_wr = 1'b1; lb_addr = bb[i];
			lb_wdata = 18'h15555 ^ 18'(i);
			tick(1);
		end
		// back-to-back reads; each answer lands two edges later
		for (int j = 0; j < 5; j++) begin
			la_wr = 1'b0; lb_wr = 1'b0; la_en = (j < 4); lb_en = (j < 4);
			if (j < 4) begin
				la_addr = bb[j];
				lb_addr = aa[j];
			end
			tick(1);
			if (j > 0) chk(la_rdata, 18'h15555 ^ 18'(j - 1));
			if (j > 0) chk(lb_rdata, 18'h3FFFF ^ 18'(j - 1));
		end
		// both ports write one word at once: port b wins the clash
		la_en = 1'b1; lb_en = 1'b1; la_wr = 1'b1; lb_wr = 1'b1;
		la_addr = 10'h155; lb_addr = 10'h155;
		la_wdata = 18'h0AAAA; lb_wdata = 18'h12345;
		tick(1);
		la_wr = 1'b0; lb_wr = 1'b0;
		tick(1);
		la_en = 1'b0; lb_en = 1'b0;
		tick(1);
		chk(la_rdata, 18'h12345);
		chk(lb_rdata, 18'h12345);
	endtask

	// pipe hold and clear act apart from the array controls
	task automatic t_pipe;
		la_pipe_en = 1'b0; lb_pipe_en = 1'b0;
		la_en = 1'b1; la_addr = aa[0]; lb_en = 1'b1; lb_addr = bb[0];
		tick(3);
		la_en = 1'b0; lb_en = 1'b0;
		chk(la_rdata, 18'h12345);
		chk(lb_rdata, 18'h12345);
		// clear must beat a load on port a while port b loads
		la_pipe_rst = 1'b1; la_pipe_en = 1'b1; lb_pipe_en = 1'b1;
		tick(1);
		chk(la_rdata, 18'h00000);
		chk(lb_rdata, 18'h15555);
		la_pipe_rst = 1'b0;
		tick(1);
		chk(la_rdata, 18'h3FFFF);
	endtask

	// fill by port c, then async port a and clocked port b at once
	task automatic t_micro;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(66);
		chk(18'(fill_busy), 18'h00000);
		ma_sync = 1'b0; mb_sync = 1'b1; mb_en = 1'b1;
		for (int i = 0; i < 64; i++) begin
			ma_addr = 6'(i); mb_addr = 6'(63 - i);
			#1 chk(ma_rdata, pat(i));
			tick(1);
			chk(mb_rdata, pat(63 - i));
		end
		mb_en = 1'b0; mb_addr = 6'h05;
		tick(2);
		chk(mb_rdata, pat(0));
		// swap modes: a clocked, b async, while port c refills
		ma_sync = 1'b1; ma_en = 1'b1; mb_sync = 1'b0;
		ma_addr = 6'h3F; mb_addr = 6'h00; start = 1'b1;
		tick(1);
		start = 1'b0; ma_en = 1'b0; ma_addr = 6'h01;
		chk(ma_rdata, pat(63));
		chk(mb_rdata, pat(0));
		tick(2);
		chk(ma_rdata, pat(63));
		chk(mb_rdata, pat(0));
	endtask

	// reset, then the scenarios in turn
	initial begin
		arst_n = 1'b0; start = 1'b0; la_en = 1'b0; la_wr = 1'b0;
		lb_en = 1'b0; lb_wr = 1'b0; la_pipe_en = 1'b1; lb_pipe_en = 1'b1;
		la_pipe_rst = 1'b0; lb_pipe_rst = 1'b0; ma_sync = 1'b0;
		ma_en = 1'b0; mb_sync = 1'b1; mb_en = 1'b0;
		la_addr = '0; lb_addr = '0; ma_addr = '0; mb_addr = '0;
		la_wdata = '0; lb_wdata = '0;
		repeat (16) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		tick(1);
		chk(la_rdata, 18'h00000);
		chk(mb_rdata, 18'h00000);
		t_large;
		t_pipe;
		t_micro;
		stop_test;
	end

	// cut a hang short well past the expected run
	initial begin
		#20000;
		bad_count++;
		stop_test;
	end
endmodule
